// ### rtl/periodic_timer_pkg.sv
package periodic_timer_pkg;
  // counter and comparator width
  localparam int CNT_W = 10;
  // wishbone byte address width and data width
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  // register byte offsets, one aligned word each
  localparam logic [ADR_W-1:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CONTROL_1 = 8'h04;
  localparam logic [ADR_W-1:0] OFS_COUNTER_LOW = 8'h08;
  localparam logic [ADR_W-1:0] OFS_COUNTER_HIGH = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_MATCH_A_LOW = 8'h10;
  localparam logic [ADR_W-1:0] OFS_MATCH_A_HIGH = 8'h14;
  localparam logic [ADR_W-1:0] OFS_PERIOD_LOW = 8'h18;
  localparam logic [ADR_W-1:0] OFS_PERIOD_HIGH = 8'h1c;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h20;
  // control 0 field positions
  localparam int POS_RUN = 3;
  localparam int POS_EXT_CLK = 4;
  // control 1 field positions
  localparam int POS_MODE_HI = 7;
  localparam int POS_MODE_LO = 6;
  localparam int POS_ACT_HI = 5;
  localparam int POS_ACT_LO = 4;
  localparam int POS_LEVEL = 3;
  localparam int POS_INVERT = 2;
  localparam int POS_CAP_SRC = 1;
  localparam int POS_CLR_SEL = 0;
  // status field positions
  localparam int POS_FLAG_A = 0;
  localparam int POS_FLAG_P = 1;
  localparam int POS_CAP_LVL = 2;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] RST_CNT = 10'h000;
  // input synchroniser depth
  localparam int SYNC_STAGES = 3;
  // operating modes
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } op_mode_e;
  // pin action codes, compare mode
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // pin action codes, pwm mode
  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;
endpackage

// ### rtl/pin_sync_if.sv
`timescale 1ns/1ps
// synchronised pin levels and events passed to the timer core
interface pin_sync_if;
  logic ext_clk_level; // filtered level of the external clock pin
  logic ext_clk_rise; // one-cycle pulse on its rising edge
  logic cap_level; // filtered level of the capture input pin
  modport src (
    output ext_clk_level,
    output ext_clk_rise,
    output cap_level
  );
  modport dst (
    input ext_clk_level,
    input ext_clk_rise,
    input cap_level
  );
endinterface

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser and edge detector for the timer input pins
module pin_sync
  import periodic_timer_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic external_clock_pin_i,
  input wire logic capture_input_pin_i,
  pin_sync_if.src sync
);
  // the agreement filter needs at least three stages
  if (STAGES < 3) begin : g_check
    $error("pin_sync needs STAGES of at least 3");
  end

  typedef struct packed {
    logic [STAGES-1:0] clk_sh; // external clock shift chain
    logic [STAGES-1:0] cap_sh; // capture pin shift chain
    logic clk_lvl; // accepted clock level
    logic clk_rise; // rising edge pulse
    logic cap_lvl; // accepted capture level
  } sync_s;

  sync_s s_r;
  sync_s s_nxt;

  // shift, then accept a level only once the last two stages agree;
  // the first stage is read by the shift alone, never by the filter
  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_sh = {s_r.clk_sh[STAGES-2:0], external_clock_pin_i};
    s_nxt.cap_sh = {s_r.cap_sh[STAGES-2:0], capture_input_pin_i};
    s_nxt.clk_rise = 1'b0;
    if (s_r.clk_sh[STAGES-1] == s_r.clk_sh[STAGES-2]) begin
      s_nxt.clk_lvl = s_r.clk_sh[STAGES-1];
      s_nxt.clk_rise = s_r.clk_sh[STAGES-1] & ~s_r.clk_lvl;
    end
    if (s_r.cap_sh[STAGES-1] == s_r.cap_sh[STAGES-2]) begin
      s_nxt.cap_lvl = s_r.cap_sh[STAGES-1];
    end
  end

  // synchronous reset to all zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync.ext_clk_level = s_r.clk_lvl;
  assign sync.ext_clk_rise = s_r.clk_rise;
  assign sync.cap_level = s_r.cap_lvl;
endmodule // pin_sync

// ### rtl/periodic_timer.sv
`timescale 1ns/1ps
// Operation
// - run rising edge restores pin initial level
// - level bit: initial or active output level
// - invert bit flips pin, not in timer or capture
// - capture source: zero capture pin, one clock
// - clear select: A match, else P/overflow
// - overflow clears only when period is zero
// - clear select ignored in pwm and capture
// - counter readable as low and two-bit high
// - mode codes: compare, capture, pwm, timer
// - P clearing in compare raises both flags
// - A clearing raises only the A flag
// - compare pin changes only on A match
// - timer mode counts like compare, no pin
// - pwm: P match clears, A sets duty
// - pwm period is P, zero gives 1024
// - duty at or above period stays active
// - forced pwm pin keeps counting running
// - pwm raises A and P match flags
// - run rise zeroes counter, fall holds it
// - pwm pin codes: inactive, active, waveform
module periodic_timer
  import periodic_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_clock_pin_i,
  input wire logic capture_input_pin_i,
  output logic waveform_output_pin_o,
  output logic waveform_output_oe_o
);

  // register map, one byte in the low lane of each aligned word:
  //   control 0 holds run at bit 3 and the external clock select
  //   control 1 holds mode, pin action, level, invert, capture
  //     source and clear select, from bit 7 down to bit 0
  //   counter low and high are read only and read live, so a
  //   carry between the two reads can tear the value
  //   match A and period low and high are read and write
  //   status holds the two match flags, write one to clear, and
  //   the level of the selected capture source, read only
  // unmapped words answer with zero and ignore writes

  // bus timing: a request is taken on the edge where cyc and stb
  // are high and ack is low; ack and read data then stand for one
  // cycle, so a master holding stb sees a gap before the next take

  // the byte split and the widening below are written for ten bits
  if (CNT_W != 10) begin : g_width_check
    $error("periodic_timer needs CNT_W of exactly 10");
  end

  // whole state of the block in one record
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // count-up counter
    logic [CNT_W-1:0] cmp_a; // compare_a_value
    logic [CNT_W-1:0] cmp_p; // period_compare_value
    logic run; // counter_run
    logic run_q; // run as seen last cycle, for edges
    logic ext_clk; // count on external clock rising edges
    op_mode_e mode; // op_mode_select
    logic [1:0] act; // pin_action_select
    logic level; // output_level_control
    logic invert; // output_invert
    logic cap_src; // capture_source_select
    logic clr_sel; // counter_clear_select
    logic out_state; // compare mode pin state before invert
    logic flag_a; // match_a_flag
    logic flag_p; // match_p_flag
    logic ack; // bus acknowledge
    logic [DAT_W-1:0] dat; // bus read data
    logic pin; // registered waveform pin
    logic oe; // registered pin enable
  } timer_s;

  timer_s s_r;
  timer_s s_nxt;

  pin_sync_if sync ();

  // filtered external pins
  // each pin passes four flops before any logic here reads it
  pin_sync #(
    .STAGES(SYNC_STAGES)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .external_clock_pin_i(external_clock_pin_i),
    .capture_input_pin_i(capture_input_pin_i),
    .sync(sync)
  );

  // place a byte into the low or high part of a 10-bit value
  function automatic logic [CNT_W-1:0] put_byte(
    input logic [CNT_W-1:0] old,
    input logic hi,
    input logic [7:0] b
  );
    logic [CNT_W-1:0] v;
    v = old;
    if (hi) begin
      v[CNT_W-1:8] = b[CNT_W-9:0];
    end else begin
      v[7:0] = b;
    end
    return v;
  endfunction

  // widen a byte register to the bus word, upper bits read zero
  function automatic logic [DAT_W-1:0] word(input logic [7:0] b);
    return {24'h000000, b};
  endfunction

  // upper counter bits as a high-byte value
  function automatic logic [7:0] high_byte(input logic [CNT_W-1:0] v);
    return {6'h00, v[CNT_W-1:8]};
  endfunction

  // combinational next state
  always_comb begin
    // bus decode
    logic req; // request taken this cycle
    logic wr; // byte write taken this cycle
    // counter events
    logic tick; // one counter clock
    logic run_rise; // counter_run went from low to high
    logic [CNT_W-1:0] inc;
    logic hit_a;
    logic hit_p;
    logic ev_a;
    logic ev_p;
    logic clr;
    logic clr_a;
    logic clr_p;
    // pin helpers
    logic pwm_on; // pwm waveform in its active part
    logic lvl; // pin level before the invert
    logic cap_lvl; // level of the selected capture source
    logic [7:0] b; // write byte from the low lane
    req = 1'b0;
    wr = 1'b0;
    tick = 1'b0;
    run_rise = 1'b0;
    inc = '0;
    hit_a = 1'b0;
    hit_p = 1'b0;
    ev_a = 1'b0;
    ev_p = 1'b0;
    clr = 1'b0;
    clr_a = 1'b0;
    clr_p = 1'b0;
    pwm_on = 1'b0;
    lvl = 1'b0;
    cap_lvl = 1'b0;
    b = wb_dat_i[7:0];
    s_nxt = s_r;

    // one answer per request; ack is dropped the cycle after it
    // a held strobe is not taken twice while ack is up
    req = wb_cyc_i & wb_stb_i & ~s_r.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    s_nxt.ack = req;

    // capture trigger source; zero picks the capture pin
    cap_lvl = s_r.cap_src ? sync.ext_clk_level : sync.cap_level;

    // register writes; unmapped and read-only words ignore writes
    if (wr) begin
      if (wb_adr_i == OFS_CONTROL_0) begin
        s_nxt.run = b[POS_RUN];
        s_nxt.ext_clk = b[POS_EXT_CLK];
      end else if (wb_adr_i == OFS_CONTROL_1) begin
        // taken at once even while running; a glitch-free change of
        // mode or pin action is left to software stopping first
        s_nxt.mode = op_mode_e'(b[POS_MODE_HI:POS_MODE_LO]);
        s_nxt.act = b[POS_ACT_HI:POS_ACT_LO];
        s_nxt.level = b[POS_LEVEL];
        s_nxt.invert = b[POS_INVERT];
        s_nxt.cap_src = b[POS_CAP_SRC];
        s_nxt.clr_sel = b[POS_CLR_SEL];
      end else if (wb_adr_i == OFS_MATCH_A_LOW) begin
        s_nxt.cmp_a = put_byte(s_r.cmp_a, 1'b0, b);
      end else if (wb_adr_i == OFS_MATCH_A_HIGH) begin
        s_nxt.cmp_a = put_byte(s_r.cmp_a, 1'b1, b);
      end else if (wb_adr_i == OFS_PERIOD_LOW) begin
        s_nxt.cmp_p = put_byte(s_r.cmp_p, 1'b0, b);
      end else if (wb_adr_i == OFS_PERIOD_HIGH) begin
        s_nxt.cmp_p = put_byte(s_r.cmp_p, 1'b1, b);
      end else if (wb_adr_i == OFS_STATUS) begin
        // write one to clear a match flag
        clr_a = b[POS_FLAG_A];
        clr_p = b[POS_FLAG_P];
      end
    end

    // register reads show the state before this cycle's update
    // and read data is zero in every cycle that is not an answer
    s_nxt.dat = '0;
    if (req && !wb_we_i) begin
      if (wb_adr_i == OFS_CONTROL_0) begin
        s_nxt.dat = word({3'h0, s_r.ext_clk, s_r.run, 3'h0});
      end else if (wb_adr_i == OFS_CONTROL_1) begin
        s_nxt.dat = word({s_r.mode, s_r.act, s_r.level, s_r.invert,
                          s_r.cap_src, s_r.clr_sel});
      end else if (wb_adr_i == OFS_COUNTER_LOW) begin
        s_nxt.dat = word(s_r.cnt[7:0]);
      end else if (wb_adr_i == OFS_COUNTER_HIGH) begin
        s_nxt.dat = word(high_byte(s_r.cnt));
      end else if (wb_adr_i == OFS_MATCH_A_LOW) begin
        s_nxt.dat = word(s_r.cmp_a[7:0]);
      end else if (wb_adr_i == OFS_MATCH_A_HIGH) begin
        s_nxt.dat = word(high_byte(s_r.cmp_a));
      end else if (wb_adr_i == OFS_PERIOD_LOW) begin
        s_nxt.dat = word(s_r.cmp_p[7:0]);
      end else if (wb_adr_i == OFS_PERIOD_HIGH) begin
        s_nxt.dat = word(high_byte(s_r.cmp_p));
      end else if (wb_adr_i == OFS_STATUS) begin
        s_nxt.dat = word({5'h00, cap_lvl, s_r.flag_p, s_r.flag_a});
      end
    end

    // counter clock: every system clock or synced pin rising edge;
    // a pin edge reaches here about four cycles late, so the pin
    // clock must stay under a quarter of the system clock
    tick = s_r.ext_clk ? sync.ext_clk_rise : 1'b1;
    run_rise = s_r.run & ~s_r.run_q;
    s_nxt.run_q = s_r.run;

    // comparators look at the value the counter is about to take,
    // so a zero period matches exactly at overflow
    // the ten-bit sum wraps on purpose: 1023 plus one is zero
    inc = s_r.cnt + 10'h001;
    hit_a = (inc == s_r.cmp_a);
    hit_p = (inc == s_r.cmp_p);

    if (run_rise) begin
      // restart from zero with the pin at its initial level
      // no flags are raised in this cycle; counting resumes next
      s_nxt.cnt = RST_CNT;
      s_nxt.out_state = s_r.level;
    end else if (s_r.run && tick) begin
      // a stopped counter simply holds its value
      case (s_r.mode)
        MODE_PWM: begin
          // clear select plays no part here
          ev_a = hit_a;
          ev_p = hit_p;
          clr = hit_p;
        end
        MODE_CAPTURE: begin
          // only the period bound is kept in this mode
          // capture itself is not built; only the count runs here
          ev_p = hit_p;
          clr = hit_p;
        end
        default: begin
          // compare and timer modes count identically
          if (s_r.clr_sel) begin
            ev_a = hit_a;
            clr = hit_a;
          end else begin
            ev_a = hit_a;
            ev_p = hit_p;
            clr = hit_p;
          end
        end
      endcase
      s_nxt.cnt = clr ? RST_CNT : inc;
      // compare pin reacts to the A event only; hold code is a no-op
      if (s_r.mode == MODE_COMPARE && ev_a) begin
        case (s_r.act)
          ACT_LOW: s_nxt.out_state = 1'b0;
          ACT_HIGH: s_nxt.out_state = 1'b1;
          ACT_TOGGLE: s_nxt.out_state = ~s_r.out_state;
          default: s_nxt.out_state = s_r.out_state;
        endcase
      end
    end

    // flags: a match in the clearing cycle wins over the clear, so
    // software that clears a flag never loses an event it raced;
    // the flags themselves are level, no pulse leaves the block
    s_nxt.flag_a = ev_a | (s_r.flag_a & ~clr_a);
    s_nxt.flag_p = ev_p | (s_r.flag_p & ~clr_p);

    // pwm is active from the clear until the counter reaches A,
    // so a duty at or above the period never goes inactive; a duty
    // of zero never goes active, the pin then stays at its inactive
    // level for the whole period
    pwm_on = (s_nxt.cnt < s_r.cmp_a);

    // output pin; counting above carries on whatever is forced here
    case (s_r.mode)
      MODE_COMPARE: begin
        lvl = s_nxt.out_state;
        s_nxt.oe = 1'b1;
      end
      MODE_PWM: begin
        case (s_r.act)
          PWM_ACTIVE: lvl = s_r.level;
          PWM_WAVE: lvl = pwm_on ? s_r.level : ~s_r.level;
          default: lvl = ~s_r.level;
        endcase
        s_nxt.oe = 1'b1;
      end
      default: begin
        // timer and capture modes leave the pin to other functions
        // the pin is held low with its enable off, never left floating
        lvl = 1'b0;
        s_nxt.oe = 1'b0;
      end
    endcase
    s_nxt.pin = s_nxt.oe & (lvl ^ s_r.invert);
  end

  // synchronous reset; every field starts at zero, which means
  // compare mode, counter stopped, pin low and not driven; the pin
  // enable rises one cycle after reset is released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // all outputs come straight from the state record
  // so nothing combinational reaches a pin or the bus
  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign waveform_output_pin_o = s_r.pin;
  assign waveform_output_oe_o = s_r.oe;
endmodule // periodic_timer

// ### dv/periodic_timer_monitor.sv
`timescale 1ns/1ps
// port-level checks on the bus answer and the output pin
module periodic_timer_monitor
  import periodic_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic external_clock_pin_i,
  input wire logic capture_input_pin_i,
  input wire logic waveform_output_pin_o,
  input wire logic waveform_output_oe_o
);
  logic [1:0] mode_r; // shadow of the mode field, taken like the design
  // follow control 1 writes at the edge they are taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= 2'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                 wb_adr_i == OFS_CONTROL_1 && wb_sel_i[0]) begin
      mode_r <= wb_dat_i[7:6];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_follows_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_single_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  dat_idle_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  write_dat_a: assert property (
    wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0) else $error("write data");
  upper_zero_a: assert property (
    wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  pin_off_a: assert property (
    !waveform_output_oe_o |-> !waveform_output_pin_o) else $error("pin");
  mode_drive_a: assert property (
    !$past(rst_i) && mode_r == $past(mode_r) |->
    waveform_output_oe_o == !mode_r[0]) else $error("enable vs mode");
endmodule // periodic_timer_monitor
bind periodic_timer periodic_timer_monitor mon_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .external_clock_pin_i(external_clock_pin_i),
  .capture_input_pin_i(capture_input_pin_i),
  .waveform_output_pin_o(waveform_output_pin_o),
  .waveform_output_oe_o(waveform_output_oe_o));

// ### dv/pin_model.sv
`timescale 1ns/1ps
// far side: external clock source and capture signal
module pin_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic cap_lvl_i,
  output logic ext_clk_o,
  output logic cap_pin_o
);
  logic [1:0] div_r; // four cycles per half period, well under clk/4
  logic tog_r; // free toggle, gated below
  // clock stands low outside a burst, so no stray edges
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      div_r <= 2'h0;
      tog_r <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
        tog_r <= ~tog_r;
      end
    end
  end
  assign ext_clk_o = run_i & tog_r; // low at time zero
  assign cap_pin_o = cap_lvl_i;
endmodule // pin_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
// register-level regression of the periodic timer
module tb_top
  import periodic_timer_pkg::*;
();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [DAT_W-1:0] wb_wdat = 32'h0, rdat;
  logic ack, pin, oe, ext_pin, cap_pin;
  logic ext_run = 1'b0, cap_lvl = 1'b0; // partner controls
  int fails = 0, cmp_count = 0;
  // pwm cases: duty, period, control 1, window, high cycles
  logic [9:0] pa [8] = '{10'h002, 10'h001, 10'h001, 10'h006, 10'h002,
                         10'h002, 10'h002, 10'h200};
  logic [9:0] pp [8] = '{10'h004, 10'h004, 10'h004, 10'h004, 10'h004,
                         10'h004, 10'h004, 10'h000};
  logic [7:0] pc [8] = '{8'ha8, 8'hac, 8'ha0, 8'ha8, 8'h88, 8'h98, 8'ha9,
                         8'ha8};
  int pn [8] = '{40, 40, 40, 40, 40, 40, 40, 2048};
  int pe [8] = '{20, 30, 30, 40, 0, 40, 20, 1024};
  // compare cases: hold, low with high start, high
  logic [7:0] cc [3] = '{8'h01, 8'h19, 8'h21};
  logic ce [3] = '{1'b0, 1'b0, 1'b1};
  periodic_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .external_clock_pin_i(ext_pin),
    .capture_input_pin_i(cap_pin), .waveform_output_pin_o(pin),
    .waveform_output_oe_o(oe));
  pin_model model_u (.clk_i(clk_i), .run_i(ext_run), .cap_lvl_i(cap_lvl),
    .ext_clk_o(ext_pin), .cap_pin_o(cap_pin));
  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; the request stands until ack is sampled
  task automatic bus(input logic we, input logic [ADR_W-1:0] a,
                     input logic [7:0] d, output logic [DAT_W-1:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'h1;
    wb_wdat <= {24'h0, d};
    // no cycle count is assumed; a lost ack is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
    logic [DAT_W-1:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [ADR_W-1:0] a, input logic [31:0] e);
    logic [DAT_W-1:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  task automatic rd_rng(input logic [ADR_W-1:0] a, input logic [31:0] lo,
                        input logic [31:0] hi);
    logic [DAT_W-1:0] q;
    bus(1'b0, a, 8'h00, q);
    check({31'h0, q >= lo && q <= hi}, 32'h1);
  endtask
  // stop first: settings change only while the counter is off
  task automatic cfg(input logic [9:0] a, input logic [9:0] p,
                     input logic [7:0] c1, input logic [7:0] c0);
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_MATCH_A_LOW, a[7:0]);
    wr(OFS_MATCH_A_HIGH, {6'h0, a[9:8]});
    wr(OFS_PERIOD_LOW, p[7:0]);
    wr(OFS_PERIOD_HIGH, {6'h0, p[9:8]});
    wr(OFS_CONTROL_1, c1);
    wr(OFS_STATUS, 8'h03);
    wr(OFS_CONTROL_0, c0);
  endtask
  task automatic pwm_hi(input int n, input int e);
    int h;
    h = 0;
    repeat (3) @(posedge clk_i);
    repeat (n) begin
      @(posedge clk_i);
      if (pin === 1'b1) h++;
    end
    check(h, e);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) rd_chk(8'(4 * i), 32'h0);
    $display("test reset done");
    wr(OFS_MATCH_A_LOW, 8'hff);
    wr(OFS_MATCH_A_HIGH, 8'hff);
    wr(OFS_PERIOD_LOW, 8'h5a);
    wr(OFS_PERIOD_HIGH, 8'hfe);
    wr(OFS_COUNTER_LOW, 8'h77);
    rd_chk(OFS_MATCH_A_LOW, 32'hff);
    rd_chk(OFS_MATCH_A_HIGH, 32'h3);
    rd_chk(OFS_PERIOD_LOW, 32'h5a);
    rd_chk(OFS_PERIOD_HIGH, 32'h2);
    rd_chk(OFS_COUNTER_LOW, 32'h0);
    $display("test access done");
    cfg(10'h3, 10'ha, 8'hc0, 8'h08);
    repeat (40) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h3);
    check({31'h0, oe}, 32'h0);
    rd_rng(OFS_COUNTER_LOW, 0, 9);
    cfg(10'h3ff, 10'h0, 8'hc0, 8'h08);
    repeat (400) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_COUNTER_HIGH, 32'h1);
    repeat (700) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h3);
    $display("test timer done");
    for (int i = 0; i < 3; i++) begin
      cfg(10'h5, 10'h2, cc[i], 8'h08);
      repeat (40) @(posedge clk_i);
      check({31'h0, pin}, {31'h0, ce[i]});
    end
    rd_chk(OFS_STATUS, 32'h1);
    rd_rng(OFS_COUNTER_LOW, 0, 4);
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_0, 8'h08);
    repeat (2) @(posedge clk_i);
    check({31'h0, pin}, 32'h0);
    cfg(10'h5, 10'h2, 8'h31, 8'h08);
    pwm_hi(40, 20);
    $display("test compare done");
    for (int i = 0; i < 8; i++) begin
      cfg(pa[i], pp[i], pc[i], 8'h08);
      pwm_hi(pn[i], pe[i]);
    end
    cfg(10'h2, 10'h4, 8'h88, 8'h08);
    repeat (20) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h3);
    cfg(10'h1, 10'h3, 8'h41, 8'h08);
    repeat (20) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h2);
    rd_rng(OFS_COUNTER_LOW, 0, 2);
    check({31'h0, oe}, 32'h0);
    $display("test pwm done");
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_STATUS, 8'h03);
    cap_lvl <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h4);
    wr(OFS_CONTROL_1, 8'hc2);
    rd_chk(OFS_STATUS, 32'h0);
    cap_lvl <= 1'b0;
    ext_run <= 1'b1;
    cfg(10'h3ff, 10'h0, 8'hc0, 8'h18);
    repeat (160) @(posedge clk_i);
    rd_rng(OFS_COUNTER_LOW, 15, 23);
    ext_run <= 1'b0;
    $display("test pins done");
    final_report;
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    $display("[ERR] %0t watchdog", $time);
    final_report;
  end
endmodule // tb_top
